// ### rtl/ecip_pkg.sv
package ecip_pkg;

  // ==========================================================
  // register map
  localparam logic [15:0] ADDR_PIN_IRQ_SELECT  = 16'hff20;
  localparam logic [15:0] ADDR_PIN_LEVEL       = 16'hff21;
  localparam logic [15:0] ADDR_EDGE_COMPARE    = 16'hff22;
  localparam logic [15:0] ADDR_PIN_IRQ_ENABLE  = 16'hffe4;
  localparam logic [15:0] ADDR_PIN_IRQ_PENDING = 16'hfff4;

  // ==========================================================
  // widths, fields and reset values
  localparam int          PIN_COUNT          = 4;
  localparam int          TIMER_PIN_INDEX    = 3;
  localparam int          FLAG_BIT           = 0;
  localparam logic [3:0]  RESET_SELECT       = 4'h0;
  localparam logic [3:0]  RESET_COMPARE      = 4'hf;
  localparam logic        RESET_ENABLE       = 1'h0;
  localparam logic        RESET_PENDING      = 1'h0;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [3:0]  wdata;
  } ecip_bus_req_type;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] select;
    logic [3:0] compare;
    logic       enable;
    logic       pending;
    logic       matched;
    logic [3:0] rdata;
  } ecip_state_type;

endpackage

// ### rtl/ecip_port.sv
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - pin level register returns live pin levels
// - writes to pin level register ignored
// - select bit includes pin in interrupt
// - compare bit one falling, zero rising
// - only selected pins enter the match
// - interrupt when match turns to mismatch
// - mismatch to mismatch raises nothing new
// - condition sets pending regardless of enable
// - request reaches cpu only when enabled
// - write one clears pending, zero ignored
// - uncleared pending keeps requesting interrupt
// - pin interrupt also wakes from sleep
// - compare register resets to all ones
// - pending, select, enable reset to zero
// - fourth pin also feeds timer clock
module ecip_port
  import ecip_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       clk_en,
  input  wire logic [3:0]                 input_pins,
  input  wire ecip_pkg::ecip_bus_req_type bus_req,
  output logic [3:0]                      bus_rdata,
  output logic                            irq_request,
  output logic                            wake_request,
  output logic                            timer_shared_pin
);
  import ecip_pkg::*;

  ecip_state_type state;
  ecip_state_type next_state;
  logic           match_now;
  logic           irq_event;
  logic [3:0]     pin_ok;
  logic           addr_mapped;

  // ==========================================================
  // address decode, used by both read and write paths
  function automatic logic hit(input logic [15:0] a, input logic [15:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  // read multiplexer; unused flag bits come back as zero
  function automatic logic [3:0] read_value(input logic [15:0] a, input ecip_state_type s);
    read_value = 4'h0;
    if (hit(a, ADDR_PIN_IRQ_SELECT))
      read_value = s.select;
    if (hit(a, ADDR_PIN_LEVEL))
      read_value = s.sync2;
    if (hit(a, ADDR_EDGE_COMPARE))
      read_value = s.compare;
    if (hit(a, ADDR_PIN_IRQ_ENABLE))
      read_value = {3'h0, s.enable};
    if (hit(a, ADDR_PIN_IRQ_PENDING))
      read_value = {3'h0, s.pending};
  endfunction

  // any register of this block; everything else reads as zero
  assign addr_mapped = hit(bus_req.addr, ADDR_PIN_IRQ_SELECT)
                     | hit(bus_req.addr, ADDR_PIN_LEVEL)
                     | hit(bus_req.addr, ADDR_EDGE_COMPARE)
                     | hit(bus_req.addr, ADDR_PIN_IRQ_ENABLE)
                     | hit(bus_req.addr, ADDR_PIN_IRQ_PENDING);

  // ==========================================================
  // match detection
  // unselected pins are forced to match so they never change the result
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++)
    begin : g_pin
      // compare bit one expects a high pin, so a fall breaks the match
      assign pin_ok[g] = ~state.select[g] | (state.sync2[g] == state.compare[g]);
    end
  endgenerate
  assign match_now = &pin_ok;
  // only the matching-to-mismatch transition fires; mismatch to mismatch is quiet
  assign irq_event = state.matched & ~match_now;

  always_comb
  begin
    next_state = state;
    next_state.sync1 = input_pins;
    next_state.sync2 = state.sync1;
    next_state.matched = match_now;
    if (bus_req.wr && hit(bus_req.addr, ADDR_PIN_IRQ_SELECT))
      next_state.select = bus_req.wdata;
    if (bus_req.wr && hit(bus_req.addr, ADDR_EDGE_COMPARE))
      next_state.compare = bus_req.wdata;
    if (bus_req.wr && hit(bus_req.addr, ADDR_PIN_IRQ_ENABLE))
      next_state.enable = bus_req.wdata[FLAG_BIT];
    // pin level has no write path at all
    if (bus_req.wr && hit(bus_req.addr, ADDR_PIN_IRQ_PENDING) && bus_req.wdata[FLAG_BIT])
      next_state.pending = 1'b0;
    // set after clear so a same-cycle event is never lost
    if (irq_event)
      next_state.pending = 1'b1;
    // idle cycles and unmapped addresses return zero
    next_state.rdata = 4'h0;
    if (bus_req.rd)
      next_state.rdata = read_value(bus_req.addr, state);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state.sync1   <= 4'h0;
      state.sync2   <= 4'h0;
      state.select  <= RESET_SELECT;
      state.compare <= RESET_COMPARE;
      state.enable  <= RESET_ENABLE;
      state.pending <= RESET_PENDING;
      state.matched <= 1'b1;
      state.rdata   <= 4'h0;
    end
    else if (clk_en)
    begin
      state <= next_state;
    end
  end

  // ==========================================================
  // outputs
  assign bus_rdata = state.rdata;
  // level request: stays up until software clears pending
  assign irq_request = state.pending & state.enable;
  // wake needs the same enable, so software must arm it before sleeping
  assign wake_request = state.pending & state.enable;
  // the timer sees the raw pin; it runs its own noise rejection
  assign timer_shared_pin = input_pins[TIMER_PIN_INDEX];

  // ==========================================================
  // checks
  sequence s_match_lost;
    clk_en && irq_event;
  endsequence

  // one taken bus request of each kind
  sequence s_write(logic [15:0] a);
    clk_en && bus_req.wr && bus_req.addr == a;
  endsequence

  sequence s_read(logic [15:0] a);
    clk_en && bus_req.rd && bus_req.addr == a;
  endsequence

  a_pending_set_event: assert property (@(posedge clk) disable iff (rst)
    s_match_lost |=> state.pending)
    else $error("pending not set after match loss");

  a_irq_gated_enable: assert property (@(posedge clk) disable iff (rst)
    irq_request == (state.pending && state.enable))
    else $error("irq request not gated by enable");

  a_clear_write_one: assert property (@(posedge clk) disable iff (rst)
    clk_en && bus_req.wr && bus_req.addr == ADDR_PIN_IRQ_PENDING && bus_req.wdata[0]
    && !irq_event |=> !state.pending)
    else $error("pending not cleared by write one");

  a_zero_write_keeps: assert property (@(posedge clk) disable iff (rst)
    clk_en && state.pending && !(bus_req.wr && bus_req.addr == ADDR_PIN_IRQ_PENDING
    && bus_req.wdata[0]) |=> state.pending)
    else $error("pending lost without a clear");

  a_no_new_mismatch: assert property (@(posedge clk) disable iff (rst)
    clk_en && !state.matched |-> !irq_event)
    else $error("event from mismatch to mismatch");

  a_sync_two_stage: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) && !$past(rst, 2) && $past(clk_en) && $past(clk_en, 2)
    |-> state.sync2 == $past(input_pins, 2))
    else $error("synchroniser depth wrong");

  a_level_read: assert property (@(posedge clk) disable iff (rst)
    clk_en && bus_req.rd && bus_req.addr == ADDR_PIN_LEVEL |=> bus_rdata == $past(state.sync2))
    else $error("pin level read wrong");

  a_enable_upper_zero: assert property (@(posedge clk) disable iff (rst)
    clk_en && bus_req.rd && bus_req.addr == ADDR_PIN_IRQ_ENABLE |=> bus_rdata[3:1] == 3'h0)
    else $error("unused enable bits not zero");

  a_unselected_ignored: assert property (@(posedge clk) disable iff (rst)
    state.select == 4'h0 |-> match_now)
    else $error("unselected pins affect match");

  a_select_write: assert property (@(posedge clk) disable iff (rst)
    s_write(ADDR_PIN_IRQ_SELECT)
    |=> state.select == $past(bus_req.wdata))
    else $error("select write not stored");

  a_select_hold: assert property (@(posedge clk) disable iff (rst)
    clk_en && !(bus_req.wr && bus_req.addr == ADDR_PIN_IRQ_SELECT)
    |=> state.select == $past(state.select))
    else $error("select changed without a write");

  a_select_read: assert property (@(posedge clk) disable iff (rst)
    s_read(ADDR_PIN_IRQ_SELECT)
    |=> bus_rdata == $past(state.select))
    else $error("select read wrong");

  a_compare_write: assert property (@(posedge clk) disable iff (rst)
    s_write(ADDR_EDGE_COMPARE)
    |=> state.compare == $past(bus_req.wdata))
    else $error("compare write not stored");

  a_compare_hold: assert property (@(posedge clk) disable iff (rst)
    clk_en && !(bus_req.wr && bus_req.addr == ADDR_EDGE_COMPARE)
    |=> state.compare == $past(state.compare))
    else $error("compare changed without a write");

  a_compare_read: assert property (@(posedge clk) disable iff (rst)
    s_read(ADDR_EDGE_COMPARE)
    |=> bus_rdata == $past(state.compare))
    else $error("compare read wrong");

  a_enable_write: assert property (@(posedge clk) disable iff (rst)
    s_write(ADDR_PIN_IRQ_ENABLE)
    |=> state.enable == $past(bus_req.wdata[FLAG_BIT]))
    else $error("enable write not stored");

  a_enable_hold: assert property (@(posedge clk) disable iff (rst)
    clk_en && !(bus_req.wr && bus_req.addr == ADDR_PIN_IRQ_ENABLE)
    |=> state.enable == $past(state.enable))
    else $error("enable changed without a write");

  a_enable_read: assert property (@(posedge clk) disable iff (rst)
    s_read(ADDR_PIN_IRQ_ENABLE)
    |=> bus_rdata[0] == $past(state.enable))
    else $error("enable read wrong");

  a_pending_read: assert property (@(posedge clk) disable iff (rst)
    s_read(ADDR_PIN_IRQ_PENDING)
    |=> bus_rdata == {3'h0, $past(state.pending)})
    else $error("pending read wrong");

  a_level_write_quiet: assert property (@(posedge clk) disable iff (rst)
    s_write(ADDR_PIN_LEVEL)
    |=> state.select == $past(state.select) && state.compare == $past(state.compare))
    else $error("pin level write changed state");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
    clk_en && bus_req.rd && !addr_mapped
    |=> bus_rdata == 4'h0)
    else $error("unmapped read not zero");

  a_idle_rdata_zero: assert property (@(posedge clk) disable iff (rst)
    clk_en && !bus_req.rd
    |=> bus_rdata == 4'h0)
    else $error("read data not zero when idle");

  // judged from the raw registers, not from the match logic itself
  a_match_loss_sets: assert property (@(posedge clk) disable iff (rst)
    clk_en && state.matched && ((state.sync2 ^ state.compare) & state.select) != 4'h0
    |=> state.pending)
    else $error("match loss did not set pending");

  a_full_match_quiet: assert property (@(posedge clk) disable iff (rst)
    clk_en && ((state.sync2 ^ state.compare) & state.select) == 4'h0
    |-> !irq_event)
    else $error("event while selected pins match");

  a_pending_no_event: assert property (@(posedge clk) disable iff (rst)
    clk_en && !state.pending && !irq_event
    |=> !state.pending)
    else $error("pending set without an event");

  a_set_beats_clear: assert property (@(posedge clk) disable iff (rst)
    clk_en && irq_event && bus_req.wr && bus_req.addr == ADDR_PIN_IRQ_PENDING
    && bus_req.wdata[FLAG_BIT] |=> state.pending)
    else $error("same-cycle clear lost an event");

  a_mask_keeps_pending: assert property (@(posedge clk) disable iff (rst)
    clk_en && !state.enable && irq_event && !(bus_req.wr && bus_req.addr == ADDR_PIN_IRQ_ENABLE)
    |=> state.pending && !irq_request)
    else $error("masked event handled wrong");

  a_disabled_no_irq: assert property (@(posedge clk) disable iff (rst)
    !state.enable
    |-> !irq_request && !wake_request)
    else $error("request while masked");

  a_recur_uncleared: assert property (@(posedge clk) disable iff (rst)
    state.pending && state.enable
    |-> irq_request)
    else $error("uncleared pending not requesting");

  a_wake_follows_irq: assert property (@(posedge clk) disable iff (rst)
    wake_request == irq_request)
    else $error("wake request differs from interrupt");

  a_timer_pin_copy: assert property (@(posedge clk) disable iff (rst)
    timer_shared_pin == input_pins[TIMER_PIN_INDEX])
    else $error("timer pin not shared");

  a_sync_first_stage: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) && $past(clk_en)
    |-> state.sync1 == $past(input_pins))
    else $error("first synchroniser stage wrong");

  // a low enable must freeze every register, synchroniser included
  a_freeze_holds: assert property (@(posedge clk) disable iff (rst)
    !clk_en
    |=> state == $past(state))
    else $error("state moved while frozen");

  // checked while reset is held, so no disable here
  a_reset_values: assert property (@(posedge clk)
    rst |-> state.select == RESET_SELECT && state.compare == RESET_COMPARE
    && state.enable == RESET_ENABLE && state.pending == RESET_PENDING)
    else $error("reset values wrong");

endmodule
`default_nettype wire

// ### testbench/ecip_pins_model.sv
`timescale 1ns/100ps
`default_nettype none
module ecip_pins_model
(
  input  wire logic       clk,
  output logic [3:0]      pins
);
  initial pins = 4'hf;
  // ==========================================================
  // switch levels move just after an edge, then settle before use
  task automatic drive(input logic [3:0] v);
    @(posedge clk);
    #1 pins = v;
    repeat (5) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### testbench/test_edge_compare_input_port.sv
`timescale 1ns/100ps
`default_nettype none
module test_edge_compare_input_port;
  import ecip_pkg::*;
  logic             clk = 1'b0;
  logic             rst = 1'b0;
  logic             clk_en = 1'b1;
  ecip_bus_req_type req = '0;
  logic [3:0]       rdata;
  logic [3:0]       pins;
  logic             irq;
  logic             wake;
  logic             tpin;
  int               mismatches = 0;
  int               cmp_count = 0;
  always #4 clk = ~clk;
  ecip_pins_model u_ecip_pins_model (.clk(clk), .pins(pins));
  ecip_port u_ecip_port (.clk(clk), .rst(rst), .clk_en(clk_en), .input_pins(pins),
    .bus_req(req), .bus_rdata(rdata), .irq_request(irq), .wake_request(wake),
    .timer_shared_pin(tpin));
  // ==========================================================
  // helpers
  task automatic test_done;
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [3:0] exp);
    chk({1'b0, tpin, irq, wake}, exp);
  endtask
  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    @(posedge clk);
    #1 req = '{1'b0, 1'b1, a, d};
    @(posedge clk);
    #1 req = '0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [3:0] exp);
    @(posedge clk);
    #1 req = '{1'b1, 1'b0, a, 4'h0};
    @(posedge clk);
    #1 chk(rdata, exp);
    req = '0;
  endtask
  // ==========================================================
  // scenarios
  task automatic test_reset;
    rd(ADDR_PIN_IRQ_SELECT, 4'h0);
    rd(ADDR_EDGE_COMPARE, 4'hf);
    rd(ADDR_PIN_IRQ_ENABLE, 4'h0);
    rd(ADDR_PIN_IRQ_PENDING, 4'h0);
    rd(16'hff30, 4'h0);
  endtask
  task automatic test_level;
    u_ecip_pins_model.drive(4'ha);
    rd(ADDR_PIN_LEVEL, 4'ha);
    wr(ADDR_PIN_LEVEL, 4'h5);
    rd(ADDR_PIN_LEVEL, 4'ha);
    chk_out(4'h4);
  endtask
  task automatic test_irq;
    u_ecip_pins_model.drive(4'hf);
    wr(ADDR_PIN_IRQ_SELECT, 4'h9);
    u_ecip_pins_model.drive(4'hd);
    rd(ADDR_PIN_IRQ_PENDING, 4'h0);
    u_ecip_pins_model.drive(4'h5);
    rd(ADDR_PIN_IRQ_PENDING, 4'h1);
    chk_out(4'h0);
    wr(ADDR_PIN_IRQ_PENDING, 4'h0);
    rd(ADDR_PIN_IRQ_PENDING, 4'h1);
    wr(ADDR_PIN_IRQ_ENABLE, 4'hf);
    rd(ADDR_PIN_IRQ_ENABLE, 4'h1);
    chk_out(4'h3);
    wr(ADDR_PIN_IRQ_PENDING, 4'h1);
    rd(ADDR_PIN_IRQ_PENDING, 4'h0);
    chk_out(4'h0);
    u_ecip_pins_model.drive(4'h4);
    rd(ADDR_PIN_IRQ_PENDING, 4'h0);
  endtask
  task automatic test_rise;
    wr(ADDR_EDGE_COMPARE, 4'h6);
    rd(ADDR_EDGE_COMPARE, 4'h6);
    u_ecip_pins_model.drive(4'h5);
    rd(ADDR_PIN_IRQ_PENDING, 4'h1);
    chk_out(4'h3);
  endtask
  task automatic test_freeze;
    wr(ADDR_PIN_IRQ_PENDING, 4'h1);
    rd(ADDR_PIN_IRQ_PENDING, 4'h0);
    @(posedge clk);
    #1 clk_en = 1'b0;
    wr(ADDR_EDGE_COMPARE, 4'h0);
    u_ecip_pins_model.drive(4'h4);
    chk_out(4'h0);
    @(posedge clk);
    #1 clk_en = 1'b1;
    rd(ADDR_EDGE_COMPARE, 4'h6);
    u_ecip_pins_model.drive(4'h5);
    rd(ADDR_PIN_IRQ_PENDING, 4'h1);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    // raised off time zero so the asynchronous reset sees a real edge
    #1 rst = 1'b1;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    test_reset();
    test_level();
    test_irq();
    test_rise();
    test_freeze();
    test_done();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire
